/* File: common/obr_pkg.sv */
// package: offsets, field layout, reset values and select codes for obr
package obr_pkg;

  // register offsets on the configuration page
  localparam logic [7:0] OBR_ADDR_SRC_SEL = 8'h0d;
  localparam logic [7:0] OBR_ADDR_UNLOCK_LVL = 8'h0e;
  localparam logic [7:0] OBR_ADDR_STATUS = 8'h20;
  localparam logic [7:0] OBR_ADDR_TIMING_NOW = 8'h21;

  // reset values
  localparam logic [7:0] OBR_SRC_SEL_RST = 8'h00;
  localparam logic [7:0] OBR_UNLOCK_LVL_RST = 8'h00;
  localparam logic [7:0] OBR_READ_ZERO = 8'h00;

  // field layout of the source select register
  localparam int OBR_SEL_LSB = 0;
  localparam int OBR_SEL_W = 4;

  // bit positions of the unlock level register and timing outputs
  localparam int OBR_BIT_PHASE_A1 = 7;
  localparam int OBR_BIT_PHASE_A2 = 6;
  localparam int OBR_BIT_PHASE_B1 = 5;
  localparam int OBR_BIT_PHASE_B2 = 4;
  localparam int OBR_BIT_PHASE_C1 = 3;
  localparam int OBR_BIT_PHASE_C2 = 2;
  localparam int OBR_BIT_RESET_GATE = 1;
  localparam int OBR_BIT_CLAMP_PULSE = 0;
  localparam int OBR_TIMING_W = 8;

  // status register fields
  localparam int OBR_STAT_UNLOCKED = 0;
  localparam int OBR_STAT_LANE_EN = 1;

  // parity spans
  localparam int OBR_PAR_WIDE = 21;
  localparam int OBR_PAR_NARROW = 14;

  // remapped output bit position, lanes of legacy control bits and line index width
  localparam int OBR_REMAP_POS = 5;
  localparam int OBR_LEGACY_W = 5;
  localparam int OBR_LINE_W = 2;

  // source select codes
  typedef enum logic [3:0] {
    OBR_SEL_NORMAL = 4'b0000,
    OBR_SEL_LEGACY0 = 4'b0001,
    OBR_SEL_LEGACY1 = 4'b0010,
    OBR_SEL_LEGACY2 = 4'b0011,
    OBR_SEL_LEGACY3 = 4'b0100,
    OBR_SEL_LEGACY4 = 4'b0101,
    OBR_SEL_RED = 4'b0110,
    OBR_SEL_GREEN = 4'b0111,
    OBR_SEL_BLUE = 4'b1000,
    OBR_SEL_PARITY = 4'b1001,
    OBR_SEL_PING = 4'b1010,
    OBR_SEL_LINE_LSB = 4'b1011,
    OBR_SEL_LINE_MSB = 4'b1100,
    OBR_SEL_BLACK = 4'b1101,
    OBR_SEL_WHITE = 4'b1110,
    OBR_SEL_CLAMP = 4'b1111
  } obr_sel_t;

  // lock state of the timing outputs
  typedef enum logic [0:0] {
    OBR_ST_LOCKED = 1'b0,
    OBR_ST_UNLOCKED = 1'b1
  } obr_lock_st_t;

endpackage

/* File: common/obr_status_if.sv */
// interface: pixel status indications and the remapped bit between modules
`timescale 1ns/1ps
interface obr_status_if;
  import obr_pkg::*;
  logic normal_bit;
  logic [OBR_LEGACY_W-1:0] legacy_ctrl;
  logic red_pixel;
  logic green_pixel;
  logic blue_pixel;
  logic [OBR_PAR_WIDE-1:0] parity_word;
  logic first_serial_lane_en;
  logic ping_pixel;
  logic [OBR_LINE_W-1:0] line_index;
  logic black_loop_pixel;
  logic white_loop_pixel;
  logic input_clamp_switch;
  logic [OBR_SEL_W-1:0] select;
  logic remap_bit;

  modport src (
    output normal_bit, legacy_ctrl, red_pixel, green_pixel, blue_pixel,
    output parity_word, first_serial_lane_en, ping_pixel, line_index,
    output black_loop_pixel, white_loop_pixel, input_clamp_switch, select,
    input remap_bit
  );
  modport sink (
    input normal_bit, legacy_ctrl, red_pixel, green_pixel, blue_pixel,
    input parity_word, first_serial_lane_en, ping_pixel, line_index,
    input black_loop_pixel, white_loop_pixel, input_clamp_switch, select,
    output remap_bit
  );
endinterface

/* File: logic/obr_bit_select.sv */
// module: combinational source selector for the remapped output bit
`timescale 1ns/1ps
module obr_bit_select
  import obr_pkg::*;
(
  // status in, selected bit out
  obr_status_if.sink st
);

  // parity over the wide or narrow span, chosen by the first lane enable
  function automatic logic span_parity(
    input logic [OBR_PAR_WIDE-1:0] word,
    input logic wide
  );
    logic acc;
    acc = 1'b0;
    for (int i = 0; i < OBR_PAR_WIDE; i++) begin
      if (wide || i < OBR_PAR_NARROW) begin
        acc = acc ^ word[i];
      end
    end
    return acc;
  endfunction

  logic par_bit;
  logic sel_bit;
  obr_sel_t sel;

  assign sel = obr_sel_t'(st.select);
  assign par_bit = span_parity(st.parity_word, st.first_serial_lane_en);

  always_comb begin
    case (sel)
      OBR_SEL_NORMAL: sel_bit = st.normal_bit;
      OBR_SEL_LEGACY0: sel_bit = st.legacy_ctrl[0];
      OBR_SEL_LEGACY1: sel_bit = st.legacy_ctrl[1];
      OBR_SEL_LEGACY2: sel_bit = st.legacy_ctrl[2];
      OBR_SEL_LEGACY3: sel_bit = st.legacy_ctrl[3];
      OBR_SEL_LEGACY4: sel_bit = st.legacy_ctrl[4];
      OBR_SEL_RED: sel_bit = st.red_pixel;
      OBR_SEL_GREEN: sel_bit = st.green_pixel;
      OBR_SEL_BLUE: sel_bit = st.blue_pixel;
      OBR_SEL_PARITY: sel_bit = par_bit;
      OBR_SEL_PING: sel_bit = st.ping_pixel;
      OBR_SEL_LINE_LSB: sel_bit = st.line_index[0];
      OBR_SEL_LINE_MSB: sel_bit = st.line_index[1];
      OBR_SEL_BLACK: sel_bit = st.black_loop_pixel;
      OBR_SEL_WHITE: sel_bit = st.white_loop_pixel;
      OBR_SEL_CLAMP: sel_bit = st.input_clamp_switch;
      default: sel_bit = st.normal_bit;
    endcase
  end

  assign st.remap_bit = sel_bit;

endmodule // obr_bit_select

/* File: logic/obr_remap_unlock.sv */
// module: output bit remap and unlock-state timing output levels
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module obr_remap_unlock
  import obr_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pixel data path
  input wire logic [DATA_W-1:0] pixel_data,
  output logic [DATA_W-1:0] out_data,
  // pixel status indications
  input wire logic [OBR_LEGACY_W-1:0] legacy_ctrl_bits,
  input wire logic red_pixel,
  input wire logic green_pixel,
  input wire logic blue_pixel,
  input wire logic [OBR_PAR_WIDE-1:0] parity_word,
  input wire logic first_serial_lane_en,
  input wire logic ping_pixel,
  input wire logic [OBR_LINE_W-1:0] line_index,
  input wire logic black_loop_pixel,
  input wire logic white_loop_pixel,
  input wire logic input_clamp_switch,
  // lock state and timing generator
  input wire logic unlock_active,
  input wire logic [OBR_TIMING_W-1:0] tg_waves,
  // sensor timing outputs
  output logic phase_a1_clock,
  output logic phase_a2_clock,
  output logic phase_b1_clock,
  output logic phase_b2_clock,
  output logic phase_c1_clock,
  output logic phase_c2_clock,
  output logic reset_gate_pulse,
  output logic clamp_pulse
);

  // register decode
  logic hit_sel;
  logic hit_lvl;
  logic hit_stat;
  logic hit_now;
  logic wr_sel;
  logic wr_lvl;

  assign hit_sel = reg_addr == OBR_ADDR_SRC_SEL;
  assign hit_lvl = reg_addr == OBR_ADDR_UNLOCK_LVL;
  assign hit_stat = reg_addr == OBR_ADDR_STATUS;
  assign hit_now = reg_addr == OBR_ADDR_TIMING_NOW;
  assign wr_sel = reg_wr && hit_sel;
  assign wr_lvl = reg_wr && hit_lvl;

  // software registers; upper nibble of the select register is unused
  logic [OBR_SEL_W-1:0] sel_reg;
  logic [OBR_SEL_W-1:0] sel_next;
  logic [7:0] lvl_reg;
  logic [7:0] lvl_next;

  assign sel_next = wr_sel ? reg_wdata[OBR_SEL_LSB +: OBR_SEL_W] : sel_reg;
  // written at any time; only sampled into the hold copy while locked
  assign lvl_next = wr_lvl ? reg_wdata : lvl_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg <= OBR_SRC_SEL_RST[OBR_SEL_LSB +: OBR_SEL_W];
      lvl_reg <= OBR_UNLOCK_LVL_RST;
    end else begin
      sel_reg <= sel_next;
      lvl_reg <= lvl_next;
    end
  end

  // lock state tracking
  obr_lock_st_t st_reg;
  obr_lock_st_t st_next;

  always_comb begin
    case (st_reg)
      OBR_ST_LOCKED: st_next = unlock_active ? OBR_ST_UNLOCKED : OBR_ST_LOCKED;
      OBR_ST_UNLOCKED: st_next = unlock_active ? OBR_ST_UNLOCKED : OBR_ST_LOCKED;
      default: st_next = OBR_ST_LOCKED;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= OBR_ST_LOCKED;
    end else begin
      st_reg <= st_next;
    end
  end

  // hold copy: tracks the level register while locked, frozen on entry
  // to unlock so a write made during an update cannot glitch the pins
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  logic in_unlock;

  assign in_unlock = st_next == OBR_ST_UNLOCKED;
  // keyed to the request itself: a write in the first unlocked cycle
  // must wait for the next unlock, the lagging state flop would take it
  assign hold_next = in_unlock ? hold_reg : lvl_next;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_reg <= OBR_UNLOCK_LVL_RST;
    end else begin
      hold_reg <= hold_next;
    end
  end

  // timing output selection
  logic [OBR_TIMING_W-1:0] tim_reg;
  logic [OBR_TIMING_W-1:0] tim_next;

  // unlocked: programmed levels; locked: generator waveforms
  assign tim_next = in_unlock ? hold_next : tg_waves;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tim_reg <= '0;
    end else begin
      tim_reg <= tim_next;
    end
  end

  assign phase_a1_clock = tim_reg[OBR_BIT_PHASE_A1];
  assign phase_a2_clock = tim_reg[OBR_BIT_PHASE_A2];
  assign phase_b1_clock = tim_reg[OBR_BIT_PHASE_B1];
  assign phase_b2_clock = tim_reg[OBR_BIT_PHASE_B2];
  assign phase_c1_clock = tim_reg[OBR_BIT_PHASE_C1];
  assign phase_c2_clock = tim_reg[OBR_BIT_PHASE_C2];
  assign reset_gate_pulse = tim_reg[OBR_BIT_RESET_GATE];
  assign clamp_pulse = tim_reg[OBR_BIT_CLAMP_PULSE];

  // remap selection
  obr_status_if st_if ();

  assign st_if.normal_bit = pixel_data[OBR_REMAP_POS];
  assign st_if.legacy_ctrl = legacy_ctrl_bits;
  assign st_if.red_pixel = red_pixel;
  assign st_if.green_pixel = green_pixel;
  assign st_if.blue_pixel = blue_pixel;
  assign st_if.parity_word = parity_word;
  assign st_if.first_serial_lane_en = first_serial_lane_en;
  assign st_if.ping_pixel = ping_pixel;
  assign st_if.line_index = line_index;
  assign st_if.black_loop_pixel = black_loop_pixel;
  assign st_if.white_loop_pixel = white_loop_pixel;
  assign st_if.input_clamp_switch = input_clamp_switch;
  assign st_if.select = sel_reg;

  obr_bit_select u_sel (
    .st(st_if.sink)
  );

  // output word: other bits pass, bit 5 takes the selected source
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] data_next;

  always_comb begin
    data_next = pixel_data;
    data_next[OBR_REMAP_POS] = st_if.remap_bit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_reg <= '0;
    end else begin
      data_reg <= data_next;
    end
  end

  assign out_data = data_reg;

  // read back; unmapped addresses read zero
  logic [7:0] stat_word;
  logic [7:0] rd_mux;
  logic [7:0] rdata_reg;

  always_comb begin
    stat_word = OBR_READ_ZERO;
    stat_word[OBR_STAT_UNLOCKED] = st_reg == OBR_ST_UNLOCKED;
    stat_word[OBR_STAT_LANE_EN] = first_serial_lane_en;
  end

  assign rd_mux = hit_sel ? {4'h0, sel_reg} :
                  hit_lvl ? lvl_reg :
                  hit_stat ? stat_word :
                  hit_now ? tim_reg : OBR_READ_ZERO;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= OBR_READ_ZERO;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= OBR_READ_ZERO;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule // obr_remap_unlock

/* File: tb/obr_remap_unlock_chk.sv */
// checker: port assertions for obr_remap_unlock
`timescale 1ns/1ps
module obr_remap_unlock_chk
  import obr_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // data path
  input wire logic [DATA_W-1:0] pixel_data,
  input wire logic [DATA_W-1:0] out_data,
  // status indications
  input wire logic [OBR_LEGACY_W-1:0] legacy_ctrl_bits,
  input wire logic red_pixel,
  input wire logic green_pixel,
  input wire logic blue_pixel,
  input wire logic [OBR_PAR_WIDE-1:0] parity_word,
  input wire logic first_serial_lane_en,
  input wire logic ping_pixel,
  input wire logic [OBR_LINE_W-1:0] line_index,
  input wire logic black_loop_pixel,
  input wire logic white_loop_pixel,
  input wire logic input_clamp_switch,
  // timing
  input wire logic unlock_active,
  input wire logic [OBR_TIMING_W-1:0] tg_waves,
  input wire logic phase_a1_clock,
  input wire logic phase_a2_clock,
  input wire logic phase_b1_clock,
  input wire logic phase_b2_clock,
  input wire logic phase_c1_clock,
  input wire logic phase_c2_clock,
  input wire logic reset_gate_pulse,
  input wire logic clamp_pulse
);
  logic [3:0] sel_reg;
  logic [7:0] lvl_reg;
  logic [7:0] cap_reg;
  wire par_bit = first_serial_lane_en ? ^parity_word : ^parity_word[13:0];
  wire [15:0] src = {input_clamp_switch, white_loop_pixel, black_loop_pixel,
    line_index, ping_pixel, par_bit, blue_pixel, green_pixel, red_pixel,
    legacy_ctrl_bits, pixel_data[5]};
  wire exp_bit = src[sel_reg];
  wire [7:0] tim = {phase_a1_clock, phase_a2_clock, phase_b1_clock,
    phase_b2_clock, phase_c1_clock, phase_c2_clock, reset_gate_pulse,
    clamp_pulse};
  wire wr_sel = reg_wr && reg_addr == OBR_ADDR_SRC_SEL;
  wire wr_lvl = reg_wr && reg_addr == OBR_ADDR_UNLOCK_LVL;
  wire [7:0] lvl_next = wr_lvl ? reg_wdata : lvl_reg;
  // shadow copies; the capture freezes once unlock starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg <= 4'h0;
      lvl_reg <= 8'h00;
      cap_reg <= 8'h00;
    end else begin
      if (wr_sel) sel_reg <= reg_wdata[3:0];
      lvl_reg <= lvl_next;
      if (!unlock_active) cap_reg <= lvl_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  normal_bit_a: assert property (sel_reg == 4'h0 |=>
    out_data[5] == $past(pixel_data[5])) else $error("normal bit wrong");
  remap_bit_a: assert property (1'b1 |=>
    out_data[5] == $past(exp_bit)) else $error("remapped bit wrong");
  parity_bit_a: assert property (sel_reg == OBR_SEL_PARITY |=>
    out_data[5] == $past(par_bit)) else $error("parity bit wrong");
  data_pass_a: assert property (1'b1 |=> {out_data[DATA_W-1:6],
    out_data[4:0]} == $past({pixel_data[DATA_W-1:6], pixel_data[4:0]}))
    else $error("data bits wrong");
  unlock_level_a: assert property (unlock_active |=>
    tim == cap_reg) else $error("unlock levels wrong");
  locked_follow_a: assert property (!unlock_active |=>
    tim == $past(tg_waves)) else $error("locked outputs wrong");
  sel_read_a: assert property (reg_rd && reg_addr == OBR_ADDR_SRC_SEL |=>
    reg_rdata == {4'h0, sel_reg}) else $error("select readback wrong");
  lvl_read_a: assert property (reg_rd && reg_addr == OBR_ADDR_UNLOCK_LVL |=>
    reg_rdata == lvl_reg) else $error("level readback wrong");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == OBR_READ_ZERO)
    else $error("idle read data not zero");
  cover property (unlock_active ##1 !unlock_active);
  cover property (sel_reg == OBR_SEL_PARITY && !first_serial_lane_en);
  cover property (wr_lvl && unlock_active);
  cover property (!unlock_active ##1 (unlock_active && wr_lvl));
endmodule // obr_remap_unlock_chk

/* File: tb/obr_rx_model.sv */
// partner: receiver and sensor view of the output pins
`timescale 1ns/1ps
module obr_rx_model (
  // pins from the device
  input wire logic [15:0] out_data,
  input wire logic [7:0] tim_pins,
  // what the far side sees
  output logic [15:0] rx_data,
  output logic [7:0] rx_tim
);
  // pins are taken as they stand, no retiming on this side
  assign rx_data = out_data;
  assign rx_tim = tim_pins;
endmodule // obr_rx_model

/* File: tb/obr_remap_unlock_bench.sv */
// testbench: obr_remap_unlock with queued expectations
`timescale 1ns/1ps
module obr_remap_unlock_bench;
  import obr_pkg::*;
  localparam int DATA_W = 16;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, unl = 0, pu = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, tg_waves = 0, rx_tim;
  logic [15:0] pixel_data = 0, out_data, rx_data;
  logic [4:0] legacy_ctrl_bits = 0;
  logic red_pixel = 0, green_pixel = 0, blue_pixel = 0, ping_pixel = 0;
  logic [20:0] parity_word = 0;
  logic first_serial_lane_en = 0, black_loop_pixel = 0;
  logic white_loop_pixel = 0, input_clamp_switch = 0, unlock_active = 0;
  logic [1:0] line_index = 0;
  wire phase_a1_clock, phase_a2_clock, phase_b1_clock, phase_b2_clock;
  wire phase_c1_clock, phase_c2_clock, reset_gate_pulse, clamp_pulse;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  logic [3:0] msel = 0;
  logic [7:0] mlvl = 0, mcap = 0, ptim = 0;
  int failures = 0, total_checks = 0;
  always #4 clk = ~clk;
  obr_remap_unlock #(.DATA_W(DATA_W)) obr_remap_unlock_inst (.*);
  obr_rx_model obr_rx_model_inst (.out_data(out_data), .rx_data(rx_data),
    .tim_pins({phase_a1_clock, phase_a2_clock, phase_b1_clock,
    phase_b2_clock, phase_c1_clock, phase_c2_clock, reset_gate_pulse,
    clamp_pulse}), .rx_tim(rx_tim));
  task automatic check(input string nm, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one cycle: random status, expectation noted, inputs applied
  task automatic step(input logic w, r, input logic [7:0] a, d);
    logic [15:0] pd, src;
    logic [20:0] pw;
    logic [7:0] tg, rd, tv;
    logic [11:0] m;
    pd = $urandom;
    pw = $urandom;
    tg = $urandom;
    m = $urandom;
    src = {m[2:0], m[6:5], m[4], m[3] ? ^pw : ^pw[13:0],
      m[9:7], m[11:10], pd[13:11], pd[5]};
    tv = unl ? mcap : tg;
    rd = !r ? 8'h00 : a == OBR_ADDR_SRC_SEL ? {4'h0, msel} :
      a == OBR_ADDR_UNLOCK_LVL ? mlvl :
      a == OBR_ADDR_STATUS ? {6'h00, m[3], pu} :
      a == OBR_ADDR_TIMING_NOW ? ptim : 8'h00;
    exp_q.push_back({rd, tv, pd[15:6], src[msel], pd[4:0]});
    if (w && a == OBR_ADDR_SRC_SEL) msel = d[3:0];
    if (w && a == OBR_ADDR_UNLOCK_LVL) mlvl = d;
    if (!unl) mcap = mlvl;
    pu = unl;
    ptim = tv;
    {input_clamp_switch, white_loop_pixel, black_loop_pixel} <= m[2:0];
    {line_index, ping_pixel, first_serial_lane_en} <= m[6:3];
    {blue_pixel, green_pixel, red_pixel} <= m[9:7];
    legacy_ctrl_bits <= {m[11:10], pd[13:11]};
    pixel_data <= pd;
    parity_word <= pw;
    tg_waves <= tg;
    unlock_active <= unl;
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, d};
    @(posedge clk);
  endtask
  always @(negedge clk) begin
    while (exp_q.size() > 1) begin
      e = exp_q.pop_front();
      check("out_data", rx_data, e[15:0]);
      check("timing", {8'h00, rx_tim}, e[23:16]);
      check("rdata", {8'h00, reg_rdata}, e[31:24]);
    end
  end
  initial begin
    void'($urandom(10190));
    repeat (5) @(posedge clk);
    rst <= 0;
    step(0, 1, OBR_ADDR_SRC_SEL, 0);
    step(0, 1, OBR_ADDR_UNLOCK_LVL, 0);
    step(1, 0, 8'h5a, 8'hff);
    step(0, 1, 8'h5a, 0);
    // upper nibble is written as ones and must read back as zero
    for (int c = 0; c < 16; c++) begin
      step(1, 0, OBR_ADDR_SRC_SEL, {4'hf, c[3:0]});
      step(0, 1, OBR_ADDR_SRC_SEL, 0);
      repeat (12) step(0, 0, 0, 0);
    end
    step(1, 0, OBR_ADDR_UNLOCK_LVL, 8'ha5);
    unl = 1;
    repeat (4) step(0, 0, 0, 0);
    step(1, 0, OBR_ADDR_UNLOCK_LVL, 8'h3c);
    step(0, 1, OBR_ADDR_UNLOCK_LVL, 0);
    step(0, 1, OBR_ADDR_STATUS, 0);
    step(0, 1, OBR_ADDR_TIMING_NOW, 0);
    step(0, 0, 0, 0);
    unl = 0;
    repeat (4) step(0, 0, 0, 0);
    step(0, 1, OBR_ADDR_STATUS, 0);
    step(0, 1, OBR_ADDR_TIMING_NOW, 0);
    unl = 1;
    // a write in the first unlocked cycle waits for the next unlock
    step(1, 0, OBR_ADDR_UNLOCK_LVL, 8'hc3);
    repeat (2) step(0, 0, 0, 0);
    unl = 0;
    repeat (2) step(0, 0, 0, 0);
    summarize();
  end
  // the run needs about 260 cycles; allow far more before giving up
  initial begin
    #(8 * 3000);
    failures++;
    summarize();
  end
endmodule // obr_remap_unlock_bench
bind obr_remap_unlock obr_remap_unlock_chk #(.DATA_W(DATA_W))
  obr_remap_unlock_chk_inst (.*);
